/* File: lpm_consts.vh */
// Constants for the low-power mode controller: register map, field layout, codes.
// Included by every design file of the controller; definitions only.
`ifndef LPM_CONSTS_VH
`define LPM_CONSTS_VH
`define OFF_CTRL 8'h00
`define OFF_RTCSEL 8'h04
`define OFF_STATUS 8'h08
`define OFF_WAKEMASK 8'h0C
`define OFF_WAKESRC 8'h10
`define CTRL_RESET 32'h0000_0000
`define MASK_RESET 32'h0007_FFFF
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_LPREG_BIT 2
`define CTRL_UDRV_BIT 3
`define MODE_SLEEP 2'h1
`define MODE_STOP 2'h2
`define MODE_STANDBY 2'h3
`define ST_RUN 2'h0
`define ST_SLEEP 2'h1
`define ST_STOP 2'h2
`define ST_STANDBY 2'h3
`define RTC_LSXTAL 2'h0
`define RTC_LSEXT 2'h1
`define RTC_LSRC 2'h2
`define RTC_HSDIV 2'h3
`define HS_DIV_HALF 4'hF
`define WAKE_LINES 19
`define EXT_PIN_LINES 16
`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD 3'h2
`endif

/* File: hs_div32.v */
// Divides the high-speed crystal clock by 32 as a toggle enable pair.
// Assumes the high-speed crystal clock is synchronous input sampled on ref_clk.
`timescale 1ns/10ps
`include "lpm_consts.vh"
module hs_div32 #(
  parameter HALF = `HS_DIV_HALF
)
(
  input wire ref_clk,
  input wire arst_n,
  input wire srcEdge,
  output reg divOut
);
  reg [3:0] cnt_reg;
  // Toggle every 16 source edges gives divide by 32
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg <= 4'h0;
      divOut <= 1'b0;
    end
    else if (srcEdge)
    begin
      if (cnt_reg == HALF)
      begin
        cnt_reg <= 4'h0;
        divOut <= ~divOut;
      end
      else
        cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule // hs_div32

/* File: rtc_clk_sel.v */
// Real-time clock source selection and power-availability gating.
// Assumes the source clocks arrive as synchronous levels sampled on ref_clk.
`timescale 1ns/10ps
`include "lpm_consts.vh"
module rtc_clk_sel (
  input wire ref_clk,
  input wire arst_n,
  input wire [1:0] rtcSel,
  input wire lowSpeedCrystalClock,
  input wire lowSpeedExtClock,
  input wire lowSpeedRcClock,
  input wire highSpeedCrystalClock,
  input wire hsEnabled,
  input wire batteryOnly,
  output reg rtcClk,
  output reg rtcRunning
);
  reg hsPrev_reg;
  wire hsDiv;
  wire hsRise;
  assign hsRise = highSpeedCrystalClock & ~hsPrev_reg & hsEnabled;
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      hsPrev_reg <= 1'b0;
    else
      hsPrev_reg <= highSpeedCrystalClock;
  end
  hs_div32 hs_div32_inst (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .srcEdge(hsRise),
    .divOut(hsDiv)
  );
  // Four-way selection; low-speed rc source dies on battery only
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rtcClk <= 1'b0;
      rtcRunning <= 1'b0;
    end
    else
    begin
      case (rtcSel)
        `RTC_LSXTAL:
        begin
          rtcClk <= lowSpeedCrystalClock;
          rtcRunning <= 1'b1;
        end
        `RTC_LSEXT:
        begin
          rtcClk <= lowSpeedExtClock;
          rtcRunning <= 1'b1;
        end
        `RTC_LSRC:
        begin
          rtcClk <= lowSpeedRcClock & ~batteryOnly;
          rtcRunning <= ~batteryOnly;
        end
        `RTC_HSDIV:
        begin
          rtcClk <= hsDiv;
          rtcRunning <= hsEnabled & ~batteryOnly;
        end
        default:
        begin
          rtcClk <= 1'b0;
          rtcRunning <= 1'b0;
        end
      endcase
    end
  end
endmodule // rtc_clk_sel

/* File: low_power_mode_controller.v */
// Low-power mode controller: sleep, stop and standby sequencing with wake-up.
// Assumes an AHB-Lite master, one slave per bus, and synchronous input levels.
// Contract
// - Sleep halts only the processor clock; peripherals keep running.
// - Any interrupt or event in sleep returns to run.
// - Stop gates every core-domain clock.
// - Stop disables PLL, high-speed rc and high-speed crystal.
// - Stop keeps SRAM and registers intact.
// - Stop regulator is main or low-power as configured.
// - Stop regulator is normal by default, under-drive if configured.
// - Any external event line wakes from stop.
// - Standby switches off the regulator, unpowering the core domain.
// - Standby turns off PLL and both high-speed oscillators.
// - Real-time clock selects among four sources, one is crystal/32.
// - Low-speed crystal keeps real-time clock alive everywhere.
// - Low-speed rc runs in low-power modes, not battery only.
// - Every real-time clock event interrupts and wakes any mode.
`timescale 1ns/10ps
`include "lpm_consts.vh"
module low_power_mode_controller #(
  parameter WAKE_W = `WAKE_LINES
)
(
  input wire ref_clk,
  input wire arst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire entryRequest,
  input wire peripheralIrq,
  input wire [`EXT_PIN_LINES-1:0] externalEventLines,
  input wire supplyLevelDetector,
  input wire [3:0] rtcEvents,
  input wire usbWake,
  input wire ethWake,
  input wire lowPowerTimerOne,
  input wire wakeFromStandby,
  input wire lowSpeedCrystalClock,
  input wire lowSpeedExtClock,
  input wire lowSpeedRcClock,
  input wire highSpeedCrystalClock,
  input wire batteryOnly,
  output reg cpuClkEn,
  output reg periphClkEn,
  output reg coreClkEn,
  output reg pllEn,
  output reg highSpeedRcClockEn,
  output reg highSpeedCrystalClockEn,
  output reg mainRegulatorOn,
  output reg lowPowerRegulatorOn,
  output reg underDrive,
  output reg coreRetain,
  output reg rtcIrq,
  output wire rtcClk,
  output wire rtcRunning
);
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [31:0] ctrl_reg;
  reg [1:0] rtcSel_reg;
  reg [WAKE_W-1:0] wakeMask_reg;
  reg [WAKE_W-1:0] wakeSrc_reg;
  reg [1:0] entMode_reg;
  reg entLp_reg;
  reg entUd_reg;
  reg wrPend_reg;
  reg [7:0] addr_reg;
  reg [31:0] rdata_reg;
  wire [WAKE_W-1:0] wakeLines;
  wire anyWake;
  wire take;
  wire [1:0] reqMode;
  wire [2:0] wrIdx;
  wire stopLp;
  wire stopUd;
  wire sleepWake;
  wire standbyWake;
  localparam [31:0] MASK_INIT = `MASK_RESET;
  // Bus word address decode, shared by read and write path
  function [2:0] regIndex;
    input [7:0] a;
    begin
      case (a)
        `OFF_CTRL: regIndex = 3'h1;
        `OFF_RTCSEL: regIndex = 3'h2;
        `OFF_STATUS: regIndex = 3'h3;
        `OFF_WAKEMASK: regIndex = 3'h4;
        `OFF_WAKESRC: regIndex = 3'h5;
        default: regIndex = 3'h0;
      endcase
    end
  endfunction
  // Clock tree and high-speed oscillators stay up only in run and sleep
  function clocksUp;
    input [1:0] s;
    begin
      clocksUp = (s == `ST_RUN) | (s == `ST_SLEEP);
    end
  endfunction
  // Stop wake lines: 16 pins, supply detector, rtc, usb, ethernet, timer
  assign wakeLines = {lowPowerTimerOne | ethWake, usbWake | supplyLevelDetector,
    |rtcEvents, externalEventLines};
  assign anyWake = |(wakeLines & wakeMask_reg);
  assign take = hsel & hready & (htrans == `HTRANS_NONSEQ);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign reqMode = ctrl_reg[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  assign wrIdx = regIndex(addr_reg);
  // Settings latched at entry win over bus writes made while stopped
  assign stopLp = (state_reg == `ST_STOP) ? entLp_reg : ctrl_reg[`CTRL_LPREG_BIT];
  assign stopUd = (state_reg == `ST_STOP) ? entUd_reg : ctrl_reg[`CTRL_UDRV_BIT];
  assign sleepWake = peripheralIrq | (|wakeLines);
  // Standby has lost the core domain, so only the wake pin and rtc events count
  assign standbyWake = wakeFromStandby | (|rtcEvents);
  // Data phase registers; zero wait states
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wrPend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end
    else
    begin
      // Narrow writes are dropped; reads of any size return the whole word
      wrPend_reg <= take & hwrite & (hsize == `HSIZE_WORD);
      addr_reg <= haddr[7:0];
    end
  end
  // Registers stay untouched across stop so state survives wake-up
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_reg <= `CTRL_RESET;
      rtcSel_reg <= `RTC_LSXTAL;
      wakeMask_reg <= MASK_INIT[WAKE_W-1:0];
    end
    else if (wrPend_reg)
    begin
      case (wrIdx)
        3'h1: ctrl_reg <= {28'h000_0000, hwdata[3:0]};
        3'h2: rtcSel_reg <= hwdata[1:0];
        3'h4: wakeMask_reg <= hwdata[WAKE_W-1:0];
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end
  // Sticky wake sources; set wins over a software clear
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      wakeSrc_reg <= {WAKE_W{1'b0}};
    else if (wrPend_reg && wrIdx == 3'h5)
      wakeSrc_reg <= (wakeSrc_reg & ~hwdata[WAKE_W-1:0]) | wakeLines;
    else
      wakeSrc_reg <= wakeSrc_reg | wakeLines;
  end
  // Captured in the address phase so it stands through the data phase
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_reg <= 32'h0000_0000;
    else if (take & ~hwrite)
    begin
      case (regIndex(haddr[7:0]))
        3'h1: rdata_reg <= ctrl_reg;
        3'h2: rdata_reg <= {30'h0000_0000, rtcSel_reg};
        3'h3: rdata_reg <= {26'h000_0000, rtcRunning, rtcIrq, entMode_reg, state_reg};
        3'h4: rdata_reg <= {{(32-WAKE_W){1'b0}}, wakeMask_reg};
        3'h5: rdata_reg <= {{(32-WAKE_W){1'b0}}, wakeSrc_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  // Settings captured at the moment of entry
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      entMode_reg <= 2'h0;
      entLp_reg <= 1'b0;
      entUd_reg <= 1'b0;
    end
    else if (state_reg == `ST_RUN && entryRequest)
    begin
      entMode_reg <= reqMode;
      entLp_reg <= ctrl_reg[`CTRL_LPREG_BIT];
      entUd_reg <= ctrl_reg[`CTRL_UDRV_BIT];
    end
  end
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      `ST_RUN:
      begin
        if (entryRequest)
        begin
          case (reqMode)
            `MODE_SLEEP: state_next = `ST_SLEEP;
            `MODE_STOP: state_next = `ST_STOP;
            `MODE_STANDBY: state_next = `ST_STANDBY;
            default: state_next = `ST_RUN;
          endcase
        end
      end
      `ST_SLEEP:
        if (sleepWake)
          state_next = `ST_RUN;
      `ST_STOP:
        if (anyWake)
          state_next = `ST_RUN;
      `ST_STANDBY:
        if (standbyWake)
          state_next = `ST_RUN;
      default: state_next = `ST_RUN;
    endcase
  end
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= `ST_RUN;
    else
      state_reg <= state_next;
  end
  // Outputs registered from the next state so they switch with entry
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cpuClkEn <= 1'b1;
      periphClkEn <= 1'b1;
      coreClkEn <= 1'b1;
      pllEn <= 1'b1;
      highSpeedRcClockEn <= 1'b1;
      highSpeedCrystalClockEn <= 1'b1;
      mainRegulatorOn <= 1'b1;
      lowPowerRegulatorOn <= 1'b0;
      underDrive <= 1'b0;
      coreRetain <= 1'b0;
    end
    else
    begin
      cpuClkEn <= (state_next == `ST_RUN);
      periphClkEn <= clocksUp(state_next);
      coreClkEn <= clocksUp(state_next);
      pllEn <= clocksUp(state_next);
      highSpeedRcClockEn <= clocksUp(state_next);
      highSpeedCrystalClockEn <= clocksUp(state_next);
      coreRetain <= (state_next == `ST_STOP);
      case (state_next)
        `ST_STOP:
        begin
          mainRegulatorOn <= ~stopLp;
          lowPowerRegulatorOn <= stopLp;
          underDrive <= stopUd;
        end
        `ST_STANDBY:
        begin
          mainRegulatorOn <= 1'b0;
          lowPowerRegulatorOn <= 1'b0;
          underDrive <= 1'b0;
        end
        default:
        begin
          mainRegulatorOn <= 1'b1;
          lowPowerRegulatorOn <= 1'b0;
          underDrive <= 1'b0;
        end
      endcase
    end
  end
  // Level copy of the events; all event sources share one flag
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rtcIrq <= 1'b0;
    else
      rtcIrq <= |rtcEvents;
  end
  rtc_clk_sel rtc_clk_sel_inst (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .rtcSel(rtcSel_reg),
    .lowSpeedCrystalClock(lowSpeedCrystalClock),
    .lowSpeedExtClock(lowSpeedExtClock),
    .lowSpeedRcClock(lowSpeedRcClock),
    .highSpeedCrystalClock(highSpeedCrystalClock),
    .hsEnabled(highSpeedCrystalClockEn),
    .batteryOnly(batteryOnly),
    .rtcClk(rtcClk),
    .rtcRunning(rtcRunning)
  );
endmodule // low_power_mode_controller

/* File: low_power_mode_controller_asserts.sv */
// Checker for the low-power mode controller outputs.
// Bound to the controller; sees only its ports.
`timescale 1ns/10ps
module lpm_sva (
  input wire ref_clk,
  input wire arst_n,
  input wire peripheralIrq,
  input wire [15:0] externalEventLines,
  input wire [3:0] rtcEvents,
  input wire cpuClkEn,
  input wire periphClkEn,
  input wire coreClkEn,
  input wire pllEn,
  input wire highSpeedRcClockEn,
  input wire highSpeedCrystalClockEn,
  input wire mainRegulatorOn,
  input wire lowPowerRegulatorOn,
  input wire underDrive,
  input wire coreRetain
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire sleeping = !cpuClkEn && periphClkEn;
  wire hsOff = !pllEn && !highSpeedRcClockEn && !highSpeedCrystalClockEn;
  wire noReg = !mainRegulatorOn && !lowPowerRegulatorOn;
  chk_sleep_cpu_only:
    assert property (sleeping |-> coreClkEn && pllEn && highSpeedRcClockEn && highSpeedCrystalClockEn)
    else $error("sleep gated more than the cpu");
  chk_sleep_irq_wake:
    assert property (sleeping && peripheralIrq |=> cpuClkEn && periphClkEn) else $error("sleep not left");
  chk_stop_gates_all:
    assert property (coreRetain |-> !cpuClkEn && !periphClkEn && !coreClkEn && hsOff) else $error("stop gating");
  chk_stop_one_reg:
    assert property (coreRetain |-> mainRegulatorOn != lowPowerRegulatorOn) else $error("stop regulator");
  chk_udrv_in_stop:
    assert property (underDrive |-> coreRetain) else $error("under-drive outside stop");
  chk_stop_pin_wake:
    assert property (coreRetain && |externalEventLines |=> cpuClkEn && coreClkEn && !coreRetain)
    else $error("pin did not wake stop");
  chk_standby_off:
    assert property (noReg |-> !coreClkEn && !coreRetain && hsOff) else $error("standby not off");
  chk_rtc_event_wake:
    assert property (!cpuClkEn && |rtcEvents |=> cpuClkEn) else $error("rtc event did not wake");
  cover property (sleeping);
  cover property (coreRetain && underDrive);
  cover property (noReg);
endmodule // lpm_sva

bind low_power_mode_controller lpm_sva lpm_sva_inst (.ref_clk, .arst_n, .peripheralIrq, .externalEventLines,
  .rtcEvents, .cpuClkEn, .periphClkEn, .coreClkEn, .pllEn, .highSpeedRcClockEn, .highSpeedCrystalClockEn,
  .mainRegulatorOn, .lowPowerRegulatorOn, .underDrive, .coreRetain);

/* File: cpu_wake_model.sv */
// Processor core and wake sources facing the controller.
// Called by the bench; changes outputs right after rising edges.
`timescale 1ns/10ps
module cpu_wake_model (
  input wire ref_clk,
  output logic entryRequest,
  output logic peripheralIrq,
  output logic [15:0] externalEventLines,
  output logic supplyLevelDetector,
  output logic [3:0] rtcEvents,
  output logic usbWake,
  output logic ethWake,
  output logic lowPowerTimerOne,
  output logic wakeFromStandby
);
  logic [25:0] wakeLines = 26'h000_0000;
  initial entryRequest = 1'b0;
  assign {wakeFromStandby, lowPowerTimerOne, ethWake, usbWake, supplyLevelDetector, rtcEvents, peripheralIrq,
    externalEventLines} = wakeLines;
  // Mode and regulator bits must already be written
  task automatic enter;
    @(posedge ref_clk);
    entryRequest <= 1'b1;
    @(posedge ref_clk);
    entryRequest <= 1'b0;
  endtask
  // One cycle only, so a stuck level cannot mask a missed wake
  task automatic pulse(input logic [25:0] v);
    @(posedge ref_clk);
    wakeLines <= v;
    @(posedge ref_clk);
    wakeLines <= 26'h000_0000;
  endtask
endmodule // cpu_wake_model

/* File: test_low_power_mode_controller.sv */
// Self-checking bench for the low-power mode controller.
// Drives AHB-Lite and clock-source levels; core model makes requests and wakes.
`timescale 1ns/10ps
`include "lpm_consts.vh"
module test_low_power_mode_controller;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic batteryOnly = 1'b0;
  logic [7:0] cnt = 8'h00;
  logic prev;
  int n_errors = 0;
  int total_checks = 0;
  int n;
  wire [31:0] hrdata;
  wire hreadyout, hresp, entryRequest, peripheralIrq, supplyLevelDetector, usbWake, ethWake, lowPowerTimerOne;
  wire wakeFromStandby, cpuClkEn, periphClkEn, coreClkEn, pllEn, highSpeedRcClockEn, highSpeedCrystalClockEn;
  wire mainRegulatorOn, lowPowerRegulatorOn, underDrive, coreRetain, rtcIrq, rtcClk, rtcRunning;
  wire [15:0] externalEventLines;
  wire [3:0] rtcEvents;
  wire [9:0] pw = {cpuClkEn, periphClkEn, coreClkEn, pllEn, highSpeedRcClockEn, highSpeedCrystalClockEn,
    mainRegulatorOn, lowPowerRegulatorOn, underDrive, coreRetain};
  logic [3:0] cfg [12] = '{4'h1, 4'h2, 4'hA, 4'h6, 4'hE, 4'h2, 4'h2, 4'h3, 4'h1, 4'h2, 4'h3, 4'h2};
  logic [9:0] expPw [12] = '{10'h1F8, 10'h009, 10'h00B, 10'h005, 10'h007, 10'h009, 10'h009, 10'h000, 10'h1F8,
    10'h009, 10'h000, 10'h009};
  logic [25:0] src [12] = '{26'h001_0000, 26'h000_0001, 26'h000_8000, 26'h040_0000, 26'h080_0000, 26'h020_0000,
    26'h100_0000, 26'h200_0000, 26'h002_0000, 26'h004_0000, 26'h008_0000, 26'h010_0000};
  int togg [4] = '{64, 32, 128, 8};
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cnt <= cnt + 8'h01;
  cpu_wake_model cpu_wake_model_inst (.ref_clk, .entryRequest, .peripheralIrq, .externalEventLines,
    .supplyLevelDetector, .rtcEvents, .usbWake, .ethWake, .lowPowerTimerOne, .wakeFromStandby);
  low_power_mode_controller low_power_mode_controller_inst (.ref_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .entryRequest, .peripheralIrq,
    .externalEventLines, .supplyLevelDetector, .rtcEvents, .usbWake, .ethWake, .lowPowerTimerOne, .wakeFromStandby,
    .lowSpeedCrystalClock(cnt[2]), .lowSpeedExtClock(cnt[3]), .lowSpeedRcClock(cnt[1]),
    .highSpeedCrystalClock(cnt[0]), .batteryOnly, .cpuClkEn, .periphClkEn, .coreClkEn, .pllEn, .highSpeedRcClockEn,
    .highSpeedCrystalClockEn, .mainRegulatorOn, .lowPowerRegulatorOn, .underDrive, .coreRetain, .rtcIrq, .rtcClk,
    .rtcRunning);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= `HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    hsize <= `HSIZE_WORD;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
    chk(hresp, 1'b0);
  endtask
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #500000;
    n_errors++;
    finish_test();
  end
  initial
  begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    chk(pw, 10'h3F8);
    rd(`OFF_WAKEMASK, `MASK_RESET);
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14, 32'h0000_0000);
    for (int i = 0; i < 12; i++)
    begin
      wr(`OFF_CTRL, {28'h000_0000, cfg[i]});
      cpu_wake_model_inst.enter();
      #1;
      chk(pw, expPw[i]);
      cpu_wake_model_inst.pulse(src[i]);
      #1;
      chk(pw, 10'h3F8);
      if (|src[i][20:17]) chk(rtcIrq, 1'b1);
      if (cfg[i][1:0] == `MODE_STOP) rd(`OFF_CTRL, {28'h000_0000, cfg[i]});
    end
    rd(`OFF_STATUS, 32'h0000_0028);
    rd(`OFF_WAKESRC, 32'h0007_8001);
    wr(`OFF_WAKESRC, 32'hFFFF_FFFF);
    rd(`OFF_WAKESRC, 32'h0000_0000);
    for (int s = 0; s < 4; s++)
    begin
      wr(`OFF_RTCSEL, 32'(s));
      repeat (8) @(posedge ref_clk);
      n = 0;
      prev = rtcClk;
      repeat (256)
      begin
        @(posedge ref_clk);
        if (rtcClk !== prev) n++;
        prev = rtcClk;
      end
      chk((n > togg[s] + 2 || n + 2 < togg[s]) ? n : togg[s], togg[s]);
      chk(rtcRunning, 1'b1);
    end
    batteryOnly <= 1'b1;
    wr(`OFF_RTCSEL, 32'h0000_0000);
    repeat (4) @(posedge ref_clk);
    chk(rtcRunning, 1'b1);
    wr(`OFF_RTCSEL, 32'h0000_0002);
    repeat (4) @(posedge ref_clk);
    chk(rtcRunning, 1'b0);
    batteryOnly <= 1'b0;
    wr(`OFF_CTRL, 32'h0000_0002);
    cpu_wake_model_inst.enter();
    repeat (4) @(posedge ref_clk);
    chk(rtcRunning, 1'b1);
    cpu_wake_model_inst.pulse(26'h000_0004);
    #1;
    chk(pw, 10'h3F8);
    finish_test();
  end
endmodule // test_low_power_mode_controller
